// ---- rtl/fpe_ctrl.sv ----
// program, erase and suspend/resume sequencer with its serial command front end
`timescale 1ns/1ps
module fpe_ctrl #(
  parameter logic [31:0] PP_CYC = fpe_pkg::PP_CYC,
  parameter logic [31:0] SSE_CYC = fpe_pkg::SSE_CYC,
  parameter logic [31:0] SE_CYC = fpe_pkg::SE_CYC,
  parameter logic [31:0] DIE_CYC = fpe_pkg::DIE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sck_link_i,
  input wire logic cs_n_i,
  input wire logic [3:0] serial_io_lines_i,
  input wire fpe_pkg::fpe_proto_t proto_i,
  input wire logic addr4_nv_i,
  input wire logic prot_hit_i,
  input wire logic any_lock_i,
  input wire logic arr_fail_i,
  output logic wel_o,
  output logic wip_o,
  output logic [7:0] flag_status_o,
  output logic addr4_o,
  output logic [31:0] prot_addr_o,
  output fpe_pkg::fpe_arr_t arr_o,
  output logic arr_go_o,
  output logic arr_halt_o
);
  typedef struct packed {
    fpe_pkg::fpe_state_t st;
    logic cs1;
    logic cs2;
    logic cs3;
    logic seen;
    logic loaded;
    fpe_pkg::fpe_proto_t proto;
    logic addr4;
    logic wel;
    logic wip;
    logic [7:0] fs;
    fpe_pkg::fpe_arr_t cur;
    logic [31:0] tmr;
    logic [31:0] sl;
    logic e_susp;
    fpe_pkg::fpe_arr_t e_op;
    logic [31:0] e_rem;
    logic p_susp;
    fpe_pkg::fpe_arr_t p_op;
    logic [31:0] p_rem;
    logic [31:0] prot_addr;
    logic go;
    logic halt;
    logic [11:0] sw_age; // cycles spent waiting to park, read only by the latency check
  } fpe_sys_t;

  fpe_sys_t s_reg, s_next;
  fpe_pkg::fpe_lnk_t l_reg, l_next;
  fpe_pkg::fpe_rec_t r_reg, r_next;

  // shift one transfer of w lines into a word, highest line first
  function automatic logic [31:0] shin(logic [31:0] v, logic [3:0] d, logic [2:0] w);
    unique case (w)
      3'h1: shin = {v[30:0], d[0]};
      3'h2: shin = {v[29:0], d[1:0]};
      default: shin = {v[27:0], d};
    endcase
  endfunction

  // address bits carried by an opcode
  function automatic logic [5:0] abits(logic [7:0] op, logic a4);
    unique case (op)
      fpe_pkg::OPC_PP4, fpe_pkg::OPC_QP4, fpe_pkg::OPC_EQP4,
      fpe_pkg::OPC_SSE4, fpe_pkg::OPC_SE4: abits = fpe_pkg::A4_BITS; // [R01] [R02]
      fpe_pkg::OPC_PP, fpe_pkg::OPC_QP, fpe_pkg::OPC_EQP, fpe_pkg::OPC_SSE,
      fpe_pkg::OPC_SE: abits = a4 ? fpe_pkg::A4_BITS : fpe_pkg::A3_BITS; // [R03]
      default: abits = 6'h00;
    endcase
  endfunction

  // lines used per clock in each phase; extended mode widens only where the opcode says
  function automatic logic [2:0] lanes(fpe_pkg::fpe_proto_t pr, logic [7:0] op,
                                       fpe_pkg::fpe_phase_t ph);
    if (pr == fpe_pkg::PR_QUAD) begin
      lanes = 3'h4;
    end else if (pr == fpe_pkg::PR_DUAL) begin
      lanes = 3'h2;
    end else if (ph == fpe_pkg::L_OP) begin
      lanes = 3'h1;
    end else if (op == fpe_pkg::OPC_EQP || op == fpe_pkg::OPC_EQP4) begin
      lanes = 3'h4;
    end else if (ph == fpe_pkg::L_DATA && (op == fpe_pkg::OPC_QP || op == fpe_pkg::OPC_QP4)) begin
      lanes = 3'h4;
    end else begin
      lanes = 3'h1;
    end
  endfunction

  function automatic logic [31:0] dur(fpe_pkg::fpe_kind_t k);
    unique case (k)
      fpe_pkg::K_PROG: dur = PP_CYC;
      fpe_pkg::K_SSE: dur = SSE_CYC;
      fpe_pkg::K_SE: dur = SE_CYC;
      default: dur = DIE_CYC;
    endcase
  endfunction

  // link side: phase counting and capture, one edge per transfer
  logic [2:0] lw;
  logic [5:0] ab;
  logic [5:0] cnt_sum;
  logic [31:0] op_w;
  always_comb begin
    l_next = l_reg;
    r_next = r_reg;
    r_next.a4_s1 = s_reg.addr4;
    r_next.a4_s2 = r_reg.a4_s1;
    r_next.pr_s1 = s_reg.proto;
    r_next.pr_s2 = r_reg.pr_s1;
    lw = lanes(r_reg.pr_s2, r_reg.op, l_reg.ph);
    cnt_sum = 6'(l_reg.cnt + 6'(lw));
    op_w = shin({24'h000000, r_reg.op}, serial_io_lines_i, lw);
    ab = abits(op_w[7:0], r_reg.a4_s2);
    if (l_reg.ph == fpe_pkg::L_OP && l_reg.cnt == 6'h00) begin
      r_next.tog = ~r_reg.tog; // marks a new frame for the system side
      r_next.ok = 1'b0;
    end
    unique case (l_reg.ph)
      fpe_pkg::L_OP: begin
        r_next.op = op_w[7:0];
        l_next.cnt = cnt_sum;
        if (cnt_sum == fpe_pkg::OP_BITS) begin // [R04]
          l_next.cnt = 6'h00;
          l_next.ph = (ab == 6'h00) ? fpe_pkg::L_DATA : fpe_pkg::L_ADDR;
          r_next.ok = (ab == 6'h00);
          r_next.addr = 32'h0000_0000;
          r_next.nby = 16'h0000;
        end
      end
      fpe_pkg::L_ADDR: begin
        r_next.addr = shin(r_reg.addr, serial_io_lines_i, lw); // sampled on rising edge [R12]
        l_next.cnt = cnt_sum;
        if (cnt_sum == abits(r_reg.op, r_reg.a4_s2)) begin // [R04]
          l_next.ph = fpe_pkg::L_DATA;
          r_next.ok = 1'b1;
        end
      end
      default: begin
        l_next.bib = 3'(l_reg.bib + lw);
        r_next.ok = (l_next.bib == 3'h0); // byte boundary only [R07]
        if (l_next.bib == 3'h0) begin
          r_next.nby = 16'(r_reg.nby + 16'h0001);
        end
      end
    endcase
  end

  // counters clear whenever chip select is high, so each frame starts fresh
  always_ff @(posedge sck_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      l_reg <= '{ph: fpe_pkg::L_OP, cnt: 6'h00, bib: 3'h0};
    end else begin
      l_reg <= l_next;
    end
  end

  // record holds still while the clock is idle, so the system side reads it safely
  // no link clock runs during reset, so the record clears asynchronously; a frame
  // toggle that started unknown would never match the system side
  always_ff @(posedge sck_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // system side decode helpers
  logic fr_end;
  logic busy;
  logic is_prog;
  logic is_erase;
  logic ev_resume;
  logic ev_prot_e;
  fpe_pkg::fpe_kind_t ek;
  always_comb begin
    fr_end = s_reg.cs2 && !s_reg.cs3 && (r_reg.tog != s_reg.seen);
    busy = (s_reg.st != fpe_pkg::ST_IDLE);
    is_prog = 1'b0;
    is_erase = 1'b0;
    ek = fpe_pkg::K_SSE;
    unique case (r_reg.op)
      fpe_pkg::OPC_PP, fpe_pkg::OPC_PP4, fpe_pkg::OPC_QP, fpe_pkg::OPC_QP4,
      fpe_pkg::OPC_EQP, fpe_pkg::OPC_EQP4: is_prog = 1'b1;
      fpe_pkg::OPC_SSE, fpe_pkg::OPC_SSE4: is_erase = 1'b1;
      fpe_pkg::OPC_SE, fpe_pkg::OPC_SE4: begin
        is_erase = 1'b1;
        ek = fpe_pkg::K_SE;
      end
      fpe_pkg::OPC_DIE: begin
        is_erase = 1'b1;
        ek = fpe_pkg::K_DIE;
      end
      default: ;
    endcase
    ev_resume = fr_end && r_reg.ok && r_reg.op == fpe_pkg::OPC_RES && !busy &&
                (s_reg.p_susp || s_reg.e_susp);
    ev_prot_e = (s_reg.st == fpe_pkg::ST_CHECK) && (s_reg.cur.kind != fpe_pkg::K_PROG) &&
                ((s_reg.cur.kind == fpe_pkg::K_DIE) ? any_lock_i : prot_hit_i);
  end

  // system side sequencer
  always_comb begin
    s_next = s_reg;
    s_next.cs1 = cs_n_i;
    s_next.cs2 = s_reg.cs1;
    s_next.cs3 = s_reg.cs2;
    s_next.proto = proto_i;
    s_next.go = 1'b0;
    s_next.halt = 1'b0;
    s_next.sw_age = (s_reg.st == fpe_pkg::ST_SUSW) ? 12'(s_reg.sw_age + 12'h001) : 12'h000;
    if (!s_reg.loaded) begin
      s_next.addr4 = addr4_nv_i; // nonvolatile width choice caught after reset [R03]
      s_next.loaded = 1'b1;
    end
    if (fr_end) begin
      s_next.seen = r_reg.tog;
    end
    // commands act only when chip select rose on a whole byte [R07]
    if (fr_end && r_reg.ok) begin
      unique case (r_reg.op)
        fpe_pkg::OPC_WREN: if (!busy) s_next.wel = 1'b1;
        fpe_pkg::OPC_WRDI: if (!busy) s_next.wel = 1'b0;
        fpe_pkg::OPC_CLFS: begin
          s_next.fs[fpe_pkg::FS_EERR] = 1'b0;
          s_next.fs[fpe_pkg::FS_PERR] = 1'b0;
          s_next.fs[fpe_pkg::FS_PROT] = 1'b0;
        end
        fpe_pkg::OPC_EN4B: if (!busy) s_next.addr4 = 1'b1; // [R03]
        fpe_pkg::OPC_EX4B: if (!busy) s_next.addr4 = 1'b0; // [R03]
        fpe_pkg::OPC_SUSP: begin
          // die erase cannot be suspended; short remainders just finish [R14] [R18]
          if (s_reg.st == fpe_pkg::ST_RUN && s_reg.cur.kind != fpe_pkg::K_DIE &&
              s_reg.tmr > fpe_pkg::SUSP_LAT_CYC) begin
            s_next.st = fpe_pkg::ST_SUSW; // [R15]
            s_next.sl = fpe_pkg::SUSP_LAT_CYC;
            if (s_reg.cur.kind == fpe_pkg::K_PROG) begin
              s_next.fs[fpe_pkg::FS_PSUSP] = 1'b1; // [R16]
            end else begin
              s_next.fs[fpe_pkg::FS_ESUSP] = 1'b1; // [R16]
            end
          end
        end
        fpe_pkg::OPC_RES: begin
          // latest suspended operation resumes first [R20] [R23]
          if (ev_resume) begin
            s_next.st = fpe_pkg::ST_RUN;
            s_next.wip = 1'b1;
            s_next.fs[fpe_pkg::FS_READY] = 1'b0;
            s_next.go = 1'b1;
            if (s_reg.p_susp) begin
              s_next.p_susp = 1'b0;
              s_next.cur = s_reg.p_op;
              s_next.tmr = s_reg.p_rem;
              s_next.fs[fpe_pkg::FS_PSUSP] = 1'b0;
            end else begin
              s_next.e_susp = 1'b0;
              s_next.cur = s_reg.e_op;
              s_next.tmr = s_reg.e_rem;
              s_next.fs[fpe_pkg::FS_ESUSP] = 1'b0;
            end
          end
        end
        default: begin
          // write enable is the gate; no flag on a refused command [R06]
          if (is_prog && !busy && s_reg.wel && !s_reg.p_susp && r_reg.nby != 16'h0000) begin
            s_next.cur.kind = fpe_pkg::K_PROG;
            s_next.cur.addr = r_reg.addr;
            // only the last page worth of bytes lands, wrapping in the page [R22]
            s_next.cur.len = (r_reg.nby > fpe_pkg::PAGE_BYTES) ?
                             9'(fpe_pkg::PAGE_BYTES) : 9'(r_reg.nby);
            s_next.prot_addr = r_reg.addr;
            s_next.st = fpe_pkg::ST_CHECK;
          end else if (is_erase && !busy && s_reg.wel && !s_reg.e_susp && !s_reg.p_susp) begin
            s_next.cur.kind = ek;
            s_next.cur.len = 9'h000;
            // any address inside the region selects the whole region [R12]
            unique case (ek)
              fpe_pkg::K_SSE: s_next.cur.addr = r_reg.addr & fpe_pkg::SSE_MASK;
              fpe_pkg::K_SE: s_next.cur.addr = r_reg.addr & fpe_pkg::SE_MASK;
              default: s_next.cur.addr = 32'h0000_0000;
            endcase
            s_next.prot_addr = r_reg.addr;
            s_next.st = fpe_pkg::ST_CHECK;
          end
        end
      endcase
    end
    unique case (s_reg.st)
      fpe_pkg::ST_CHECK: begin
        s_next.st = fpe_pkg::ST_IDLE;
        if (s_reg.cur.kind == fpe_pkg::K_PROG && s_reg.e_susp &&
            s_reg.cur.addr[31:16] == s_reg.e_op.addr[31:16]) begin
          s_next.fs[fpe_pkg::FS_PERR] = 1'b1; // [R24]
        end else if (s_reg.cur.kind == fpe_pkg::K_PROG && prot_hit_i) begin
          s_next.fs[fpe_pkg::FS_PERR] = 1'b1; // latch left set [R21]
          s_next.fs[fpe_pkg::FS_PROT] = 1'b1; // [R21]
        end else if (ev_prot_e) begin
          s_next.fs[fpe_pkg::FS_EERR] = 1'b1; // latch left set [R08] [R13]
          s_next.fs[fpe_pkg::FS_PROT] = 1'b1; // [R08] [R13]
        end else begin
          s_next.st = fpe_pkg::ST_RUN;
          s_next.tmr = dur(s_reg.cur.kind); // self-timed, no host clock needed [R05] [R11]
          s_next.wip = 1'b1; // [R09]
          s_next.fs[fpe_pkg::FS_READY] = 1'b0; // [R09]
          s_next.go = 1'b1;
        end
      end
      fpe_pkg::ST_RUN, fpe_pkg::ST_SUSW: begin
        s_next.tmr = s_reg.tmr - 32'h0000_0001;
        if (s_reg.st == fpe_pkg::ST_SUSW) begin
          s_next.sl = s_reg.sl - 32'h0000_0001;
        end
        if (s_reg.st == fpe_pkg::ST_SUSW && s_reg.sl == 32'h0000_0001) begin
          // park the operation with what is left of it [R15] [R17]
          s_next.st = fpe_pkg::ST_IDLE;
          s_next.wip = 1'b0;
          s_next.fs[fpe_pkg::FS_READY] = 1'b1;
          s_next.halt = 1'b1;
          if (s_reg.cur.kind == fpe_pkg::K_PROG) begin
            s_next.p_susp = 1'b1;
            s_next.p_op = s_reg.cur;
            s_next.p_rem = s_next.tmr;
          end else begin
            s_next.e_susp = 1'b1;
            s_next.e_op = s_reg.cur;
            s_next.e_rem = s_next.tmr;
          end
        end else if (s_reg.st == fpe_pkg::ST_RUN && s_reg.tmr == 32'h0000_0001) begin
          s_next.st = fpe_pkg::ST_IDLE;
          s_next.wip = 1'b0; // [R09]
          s_next.wel = 1'b0; // cleared pass or fail [R10]
          s_next.fs[fpe_pkg::FS_READY] = 1'b1;
          if (arr_fail_i) begin
            // array reports a timeout at the end of the operation [R10]
            s_next.fs[(s_reg.cur.kind == fpe_pkg::K_PROG) ? fpe_pkg::FS_PERR
                                                          : fpe_pkg::FS_EERR] = 1'b1;
          end
        end
      end
      default: ;
    endcase
  end

  // synchronous reset; flag status powers up with only the ready bit [R19]
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.st <= fpe_pkg::ST_IDLE;
      s_reg.cs1 <= 1'b1;
      s_reg.cs2 <= 1'b1;
      s_reg.cs3 <= 1'b1;
      s_reg.fs <= fpe_pkg::FS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wel_o = s_reg.wel;
  assign wip_o = s_reg.wip;
  assign flag_status_o = s_reg.fs;
  assign addr4_o = s_reg.addr4;
  assign prot_addr_o = s_reg.prot_addr;
  assign arr_o = s_reg.cur;
  assign arr_go_o = s_reg.go;
  assign arr_halt_o = s_reg.halt;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_erase_busy_bits: assert property ( // [R09]
    (s_reg.st == fpe_pkg::ST_RUN && s_reg.cur.kind != fpe_pkg::K_PROG)
      |-> (wip_o && !flag_status_o[7]))
    else $error("erase running without busy indication");
  a_erase_no_wel: assert property ( // [R06]
    (fr_end && r_reg.ok && is_erase && !wel_o && !busy)
      |=> ($stable(flag_status_o) && s_reg.st == fpe_pkg::ST_IDLE))
    else $error("erase taken without write enable");
  a_prot_erase_flags: assert property ( // [R08]
    ev_prot_e |=> (flag_status_o[5] && flag_status_o[1] && wel_o && !wip_o))
    else $error("protected erase flags wrong");
  a_done_clears: assert property ( // [R10]
    (s_reg.st == fpe_pkg::ST_RUN && s_reg.tmr == 32'h0000_0001)
      |=> (!wel_o && !wip_o && flag_status_o[7]))
    else $error("completion did not clear latch and busy");
  a_suspend_flag_set: assert property ( // [R16]
    (s_reg.st == fpe_pkg::ST_RUN && s_next.st == fpe_pkg::ST_SUSW &&
     s_reg.cur.kind == fpe_pkg::K_PROG) |=> flag_status_o[2])
    else $error("program suspend flag missing");
  a_suspend_latency: assert property ( // [R17]
    (s_reg.st == fpe_pkg::ST_SUSW)
      |-> (!flag_status_o[7] && s_reg.sw_age < fpe_pkg::SUSP_LAT_CYC)
      ##1 (s_reg.st == fpe_pkg::ST_SUSW || (flag_status_o[7] && arr_halt_o && !wip_o)))
    else $error("suspend not reached within latency");
  a_resume_bits: assert property ( // [R23]
    ev_resume |=> (wip_o && !flag_status_o[7] && arr_go_o))
    else $error("resume did not restart operation");
  a_nest_order: assert property ( // [R20]
    (ev_resume && s_reg.p_susp && s_reg.e_susp)
      |=> (arr_o.kind == fpe_pkg::K_PROG && s_reg.e_susp))
    else $error("nested resume picked the erase first");
  a_reset_value: assert property ( // [R19]
    $rose(rst_n_i) |-> (flag_status_o == 8'h80 && !wip_o && !wel_o))
    else $error("flag status not at power-up value");
endmodule

// ---- rtl/fpe_pkg.sv ----
// package of constants, types and carriers for the flash program/erase sequencer
//
// Contract
// R01: accept opcodes 12h, 34h, 3Eh, each with a full 32-bit address.
// R02: dedicated 4-byte opcodes always use 32-bit addresses regardless of configuration.
// R03: ordinary address width set by nonvolatile setting or enter/exit 4-byte commands.
// R04: clocks to first data bit: 7, 3 or 1 plus address bits per line; the code takes 8, 4 or 2 opcode clocks before the address.
// R05: page program runs self-timed after chip select rises.
// R06: erase turns bits to one; ignored without write enable, no error flags.
// R07: chip select not rising on a byte boundary skips command, no flags.
// R08: erase to protected subsector not run; latch stays set; flags 1 and 5.
// R09: during erase controller bit reads 0, busy reads 1; busy clears at end.
// R10: latch cleared after every erase; timeout sets erase error flag.
// R11: erase duration follows the subsector, sector or die command.
// R12: subsector/sector erase clears whole region; any inside address selects it.
// R13: die erase blocked when any sector locked; latch stays set; flags 1, 5.
// R14: subsector and sector erases can be suspended and resumed.
// R15: suspend halts active program or erase within latency until resume.
// R16: program suspend sets flag bit 2; erase suspend sets flag bit 6.
// R17: after latency flag bit 7 set; host waits for bit 7 reading 1.
// R18: if remaining time below latency, finish and leave bit 2/6 clear.
// R19: suspend state volatile; flag status starts at 80h.
// R20: one nesting level: first resume restarts program, second restarts erase.
// R21: program to protected sector not run; latch stays set; flags 1 and 4.
// R22: program data past page end wraps within the same page.
// R23: resume ignored when nothing suspended; else busy 1, controller bit 0.
// R24: program to erase-suspended sector ignored; flag bit 4; latch unchanged.
// R25: host polls busy status before issuing the next program or erase.
package fpe_pkg;
  // timing, microseconds at a 50 MHz system clock
  localparam int CLK_MHZ = 50;
  localparam int PAGE_PROGRAM_DURATION_US = 500;
  localparam int SUBSECTOR_ERASE_DURATION_US = 400000;
  localparam int SECTOR_ERASE_DURATION_US = 1000000;
  localparam int DIE_ERASE_DURATION_US = 40000000;
  localparam int SUSP_LAT_US = 30;
  localparam logic [31:0] PP_CYC = 32'(PAGE_PROGRAM_DURATION_US * CLK_MHZ);
  localparam logic [31:0] SSE_CYC = 32'(SUBSECTOR_ERASE_DURATION_US * CLK_MHZ);
  localparam logic [31:0] SE_CYC = 32'(SECTOR_ERASE_DURATION_US * CLK_MHZ);
  localparam logic [31:0] DIE_CYC = 32'(DIE_ERASE_DURATION_US * CLK_MHZ);
  localparam logic [31:0] SUSP_LAT_CYC = 32'(SUSP_LAT_US * CLK_MHZ);
  // opcodes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_CLFS = 8'h50;
  localparam logic [7:0] OPC_EN4B = 8'hB7;
  localparam logic [7:0] OPC_EX4B = 8'hE9;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_PP4 = 8'h12;
  localparam logic [7:0] OPC_QP = 8'h32;
  localparam logic [7:0] OPC_QP4 = 8'h34;
  localparam logic [7:0] OPC_EQP = 8'h38;
  localparam logic [7:0] OPC_EQP4 = 8'h3E;
  localparam logic [7:0] OPC_SSE = 8'h20;
  localparam logic [7:0] OPC_SSE4 = 8'h21;
  localparam logic [7:0] OPC_SE = 8'hD8;
  localparam logic [7:0] OPC_SE4 = 8'hDC;
  localparam logic [7:0] OPC_DIE = 8'hC4;
  localparam logic [7:0] OPC_SUSP = 8'h75;
  localparam logic [7:0] OPC_RES = 8'h7A;
  // flag status bit positions and reset value
  localparam int FS_READY = 7;
  localparam int FS_ESUSP = 6;
  localparam int FS_EERR = 5;
  localparam int FS_PERR = 4;
  localparam int FS_PSUSP = 2;
  localparam int FS_PROT = 1;
  localparam logic [7:0] FS_RESET = 8'h80;
  // geometry
  localparam logic [15:0] PAGE_BYTES = 16'h0100;
  localparam logic [31:0] SSE_MASK = 32'hFFFF_F000;
  localparam logic [31:0] SE_MASK = 32'hFFFF_0000;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] A3_BITS = 6'h18;
  localparam logic [5:0] A4_BITS = 6'h20;

  typedef enum logic [1:0] {PR_EXT = 2'h0, PR_DUAL = 2'h1, PR_QUAD = 2'h2} fpe_proto_t;
  typedef enum logic [1:0] {K_PROG = 2'h0, K_SSE = 2'h1, K_SE = 2'h2, K_DIE = 2'h3} fpe_kind_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_CHECK = 4'h2, ST_RUN = 4'h4, ST_SUSW = 4'h8
  } fpe_state_t;
  typedef enum logic [2:0] {L_OP = 3'h1, L_ADDR = 3'h2, L_DATA = 3'h4} fpe_phase_t;

  // operation handed to the array
  typedef struct packed {
    fpe_kind_t kind;
    logic [31:0] addr;
    logic [8:0] len;
  } fpe_arr_t;

  // link-side frame counters, cleared by chip select
  typedef struct packed {
    fpe_phase_t ph;
    logic [5:0] cnt;
    logic [2:0] bib;
  } fpe_lnk_t;

  // link-side frame record, held after chip select rises
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] addr;
    logic [15:0] nby;
    logic ok;
    logic tog;
    logic a4_s1;
    logic a4_s2;
    fpe_proto_t pr_s1;
    fpe_proto_t pr_s2;
  } fpe_rec_t;
endpackage

// ---- test/fpe_host.sv ----
// host-side serial master model that clocks command frames into the sequencer
`timescale 1ns/1ps
module fpe_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o
);
  // the serial clock stands still low outside frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
  end

  // one frame, msb first; aw/dw are lanes for address and data, cut drops tail bits
  task automatic send(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
                      input int cut, input int aw, input int dw);
    logic [7:0] b;
    int w;
    cs_n_o = 1'b0;
    #40;
    for (int i = 0; i <= na + nd; i++) begin
      b = (i == 0) ? op : (i <= na) ? a[8 * (na - i) +: 8] : 8'hC3;
      w = (i == 0) ? 1 : (i <= na) ? aw : dw;
      for (int k = 8 - w; k >= 0 && !(i == na + nd && k < cut); k -= w) begin
        io_o = (w == 4) ? b[k +: 4] : {3'h0, b[k]};
        #31.25 sck_o = 1'b1;
        #62.5 sck_o = 1'b0;
        #31.25;
      end
    end
    #40 cs_n_o = 1'b1;
    io_o = ~io_o; // no pull on the lines, so a released line must not hold its value
    #200;
  endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the program, erase and suspend sequencer
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] a;
    logic [2:0] na;
    logic [1:0] nd;
    logic [2:0] cut;
    logic [1:0] env;
    logic wel;
    logic [7:0] fs;
    logic a4;
  } fpe_row_t;
  // command, address, byte counts, cut bits, protect/lock; then wel, flags, 4-byte mode
  fpe_row_t rows [15] = '{
    '{8'h06,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'h04,32'h0,3'h0,2'h0,3'h0,2'h0,1'h0,8'h80,1'h0},
    '{8'h20,32'h1000,3'h3,2'h0,3'h0,2'h0,1'h0,8'h80,1'h0},
    '{8'h06,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'hB7,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h1},
    '{8'hE9,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'h12,32'h10000,3'h4,2'h1,3'h3,2'h0,1'h1,8'h80,1'h0},
    '{8'h12,32'h10000,3'h4,2'h1,3'h0,2'h2,1'h1,8'h92,1'h0},
    '{8'h50,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'hDC,32'h20000,3'h4,2'h0,3'h0,2'h2,1'h1,8'hA2,1'h0},
    '{8'h50,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'hC4,32'h0,3'h0,2'h0,3'h0,2'h1,1'h1,8'hA2,1'h0},
    '{8'h50,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'h7A,32'h0,3'h0,2'h0,3'h0,2'h0,1'h1,8'h80,1'h0},
    '{8'h04,32'h0,3'h0,2'h0,3'h0,2'h0,1'h0,8'h80,1'h0}};
  logic [7:0] popc [3] = '{8'h12, 8'h34, 8'h3E};
  logic clk_sys_i, rst_n_i, sck, cs_n, prot_hit, any_lock, arr_fail;
  logic wel, wip, a4;
  logic [31:0] padr;
  logic [3:0] io;
  logic [7:0] fs;
  fpe_pkg::fpe_arr_t arr;
  int errors, compares;

  // short durations, all above the 1500-cycle suspend latency except die erase
  fpe_ctrl #(.PP_CYC(32'h0BB8), .SSE_CYC(32'h0C80), .SE_CYC(32'h0D48), .DIE_CYC(32'h00C8)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sck_link_i(sck), .cs_n_i(cs_n),
    .serial_io_lines_i(io), .proto_i(fpe_pkg::PR_EXT), .addr4_nv_i(1'b0),
    .prot_hit_i(prot_hit), .any_lock_i(any_lock), .arr_fail_i(arr_fail), .wel_o(wel),
    .wip_o(wip), .flag_status_o(fs), .addr4_o(a4), .prot_addr_o(padr), .arr_o(arr),
    .arr_go_o(), .arr_halt_o());
  fpe_host host_u (.sck_o(sck), .cs_n_o(cs_n), .io_o(io));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic st(input logic ew, input logic ewip, input logic [7:0] efs);
    chk("wel", ew, wel);
    chk("wip", ewip, wip);
    chk("flags", efs, fs);
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // bounded poll for ready and not busy, as a host must do before the next command
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (!(fs[7] === 1'b1 && wip === 1'b0)) begin
      @(posedge clk_sys_i);
      k++;
      if (k > lim) begin
        errors++;
        $display("CHECK FAILED idle wait expected ready seen busy");
        wrap_up();
      end
    end
  endtask

  task automatic wr(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
                    input int aw, input int dw);
    host_u.send(8'h06, 32'h0, 0, 0, 0, 1, 1);
    host_u.send(op, a, na, nd, 0, aw, dw);
  endtask

  initial begin
    rst_n_i = 1'b0;
    prot_hit = 1'b0;
    any_lock = 1'b0;
    arr_fail = 1'b0;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge clk_sys_i);
    st(1'b0, 1'b0, 8'h80);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    foreach (rows[i]) begin
      prot_hit <= rows[i].env[1];
      any_lock <= rows[i].env[0];
      @(posedge clk_sys_i);
      host_u.send(rows[i].op, rows[i].a, rows[i].na, rows[i].nd, rows[i].cut, 1, 1);
      st(rows[i].wel, 1'b0, rows[i].fs);
      chk("addr4", rows[i].a4, a4);
    end
    // every dedicated 4-byte program, in 3-byte mode, on its own lane widths
    foreach (popc[i]) begin
      wr(popc[i], 32'h0001_2345, 4, 2, (i == 2) ? 4 : 1, (i == 0) ? 1 : 4);
      chk("kind", fpe_pkg::K_PROG, arr.kind);
      chk("len", 32'h2, arr.len);
      chk("addr", 32'h0001_2345, arr.addr);
      chk("busy", 32'h1, {fs[7], wip});
      wait_idle(3200);
      st(1'b0, 1'b0, 8'h80);
    end
    wr(8'hC4, 32'h0, 0, 0, 1, 1);
    chk("kind", fpe_pkg::K_DIE, arr.kind);
    wait_idle(400);
    st(1'b0, 1'b0, 8'h80);
    // sector erase that times out
    arr_fail <= 1'b1;
    wr(8'hDC, 32'h0003_4567, 4, 0, 1, 1);
    chk("region", 32'h0003_0000, arr.addr);
    chk("prot", 32'h0003_4567, padr);
    chk("kind", fpe_pkg::K_SE, arr.kind);
    chk("busy", 32'h1, {fs[7], wip});
    wait_idle(3600);
    st(1'b0, 1'b0, 8'hA0);
    arr_fail <= 1'b0;
    host_u.send(8'h50, 32'h0, 0, 0, 0, 1, 1);
    // program nested inside a suspended subsector erase
    wr(8'h21, 32'h0004_1234, 4, 0, 1, 1);
    chk("region", 32'h0004_1000, arr.addr);
    host_u.send(8'h75, 32'h0, 0, 0, 0, 1, 1);
    chk("flags", 8'h40, fs);
    wait_idle(1700);
    st(1'b1, 1'b0, 8'hC0);
    host_u.send(8'h12, 32'h0004_8000, 4, 1, 0, 1, 1);
    st(1'b1, 1'b0, 8'hD0);
    host_u.send(8'h50, 32'h0, 0, 0, 0, 1, 1);
    host_u.send(8'h12, 32'h0005_0000, 4, 1, 0, 1, 1);
    host_u.send(8'h75, 32'h0, 0, 0, 0, 1, 1);
    wait_idle(1700);
    chk("flags", 8'hC4, fs);
    host_u.send(8'h7A, 32'h0, 0, 0, 0, 1, 1);
    chk("kind", fpe_pkg::K_PROG, arr.kind);
    st(1'b1, 1'b1, 8'h40);
    wait_idle(3200);
    chk("flags", 8'hC0, fs);
    host_u.send(8'h7A, 32'h0, 0, 0, 0, 1, 1);
    chk("kind", fpe_pkg::K_SSE, arr.kind);
    chk("busy", 32'h1, {fs[7], wip});
    wait_idle(3400);
    st(1'b0, 1'b0, 8'h80);
    // suspend too close to the end lets the program finish
    wr(8'h12, 32'h0006_0000, 4, 1, 1, 1);
    repeat (1700) @(posedge clk_sys_i);
    host_u.send(8'h75, 32'h0, 0, 0, 0, 1, 1);
    wait_idle(2000);
    st(1'b0, 1'b0, 8'h80);
    wrap_up();
  end
endmodule
